// >>> instr_ctrl_pkg.sv
package instr_ctrl_pkg;

    // Command codes delivered by the command parser
    typedef enum logic [4:0] {
        CMD_SET_SRQ_MASK  = 5'h00,
        CMD_QUERY_SRQ     = 5'h01,
        CMD_QUERY_STATUS  = 5'h02,
        CMD_WAIT_PENDING  = 5'h03,
        CMD_SET_RL        = 5'h04,
        CMD_QUERY_RL      = 5'h05,
        CMD_QUERY_ERROR   = 5'h06,
        CMD_IDENTIFY      = 5'h07,
        CMD_SAVE          = 5'h08,
        CMD_RECALL        = 5'h09,
        CMD_RESET         = 5'h0a,
        CMD_CLEAR_STATUS  = 5'h0b,
        CMD_ABORT         = 5'h0c,
        CMD_INITIATE      = 5'h0d,
        CMD_SET_CONT      = 5'h0e,
        CMD_BUS_TRIGGER   = 5'h0f,
        CMD_SET_VOLT      = 5'h10,
        CMD_SET_CURR      = 5'h11,
        CMD_SET_VOLT_LIM  = 5'h12,
        CMD_SET_VOLT_TRIG = 5'h13,
        CMD_SET_CURR_TRIG = 5'h14,
        CMD_SET_VOLT_PROT = 5'h15,
        CMD_SET_OUTPUT    = 5'h16,
        CMD_SET_CURR_PROT = 5'h17,
        CMD_SET_CAL       = 5'h18
    } cmd_t;

    typedef enum logic [1:0] {
        RL_LOCAL   = 2'h0,
        RL_REMOTE  = 2'h1,
        RL_LOCKOUT = 2'h2
    } rl_t;

    typedef enum logic [2:0] {
        TRIG_IDLE      = 3'b001,
        TRIG_WAITING   = 3'b010,
        TRIG_TRIGGERED = 3'b100
    } trig_state_t;

    typedef struct packed {
        logic [15:0] volt;
        logic [15:0] curr;
        logic [15:0] volt_lim;
        logic [15:0] volt_trig;
        logic [15:0] curr_trig;
        logic [15:0] volt_prot;
        logic        output_on;
        logic        curr_prot;
        logic        cal_on;
        logic        continuous_arm;
    } settings_t;

    typedef struct packed {
        logic        valid;
        cmd_t        code;
        logic [15:0] arg;
    } cmd_req_t;

    typedef struct packed {
        logic operation_summary;
        logic event_status_summary;
        logic questionable_summary;
        logic output_queue_nonempty;
    } summary_in_t;

    // Status byte field positions
    localparam int SB_OPERATION_SUMMARY = 7;
    localparam int SB_MSS  = 6;
    localparam int SB_ESB  = 5;
    localparam int SB_MAV  = 4;
    localparam int SB_QUESTIONABLE_SUMMARY = 3;
    localparam int SB_ERR  = 2;

    localparam logic [7:0]  SRQ_MASK_RESET = 8'h00;
    localparam logic [15:0] LEVEL_RESET    = 16'h0000;
    localparam logic [15:0] VOLT_PROT_MAX  = 16'hffff;
    localparam logic [15:0] NO_ERROR_CODE  = 16'h0000;
    localparam logic [15:0] OVERFLOW_CODE  = 16'hfea2;  // -350
    localparam int          ERR_DEPTH      = 8;
    localparam int          SLOT_COUNT     = 16;

    // Identity words, values arbitrary
    localparam logic [15:0] ID_MAKER    = 16'h1234;
    localparam logic [15:0] ID_MODEL    = 16'h0a5a;
    localparam logic [15:0] ID_SERIAL   = 16'h0000;
    localparam logic [15:0] ID_REVISION = 16'h0101;

    localparam settings_t SETTINGS_RESET = '{
        volt:           LEVEL_RESET,
        curr:           LEVEL_RESET,
        volt_lim:       LEVEL_RESET,
        volt_trig:      LEVEL_RESET,
        curr_trig:      LEVEL_RESET,
        volt_prot:      VOLT_PROT_MAX,
        output_on:      1'b0,
        curr_prot:      1'b0,
        cal_on:         1'b0,
        continuous_arm: 1'b0
    };

endpackage

// >>> error_queue.sv
`timescale 1ns/1ns
module error_queue (
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        rst_b_in,
    // Control
    input  wire logic        push_in,
    input  wire logic [15:0] code_in,
    input  wire logic        pop_in,
    input  wire logic        clear_in,
    // Status
    output logic      [15:0] rd_data_out,
    output logic             nonempty_out
);
    localparam int DEPTH = instr_ctrl_pkg::ERR_DEPTH;

    logic [15:0] mem [DEPTH];
    logic [2:0]  wr_ptr;
    logic [2:0]  rd_ptr;
    logic [3:0]  count;
    logic        full;
    logic        do_pop;
    logic        do_write;

    assign full     = (count == 4'(DEPTH));
    assign do_pop   = pop_in && (count != 4'h0) && !clear_in;
    assign do_write = push_in && !clear_in && (!full || do_pop);
    assign nonempty_out = (count != 4'h0);

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_ptr <= 3'h0;
            rd_ptr <= 3'h0;
            count  <= 4'h0;
        end else if (clear_in) begin
            wr_ptr <= 3'h0;
            rd_ptr <= 3'h0;
            count  <= 4'h0;
        end else begin
            if (do_pop) begin
                rd_ptr <= rd_ptr + 3'h1;
            end
            if (do_write) begin
                wr_ptr <= wr_ptr + 3'h1;
            end
            if (do_write && !do_pop) begin
                count <= count + 4'h1;
            end else if (do_pop && !do_write) begin
                count <= count - 4'h1;
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_data_out <= instr_ctrl_pkg::NO_ERROR_CODE;
        end else if (pop_in) begin
            rd_data_out <= do_pop ? mem[rd_ptr]
                                  : instr_ctrl_pkg::NO_ERROR_CODE;
        end
    end

    // Overflow overwrites the newest entry
    always_ff @(posedge clock_in) begin
        if (do_write) begin
            mem[wr_ptr] <= code_in;
        end else if (push_in && full && !clear_in) begin
            mem[wr_ptr - 3'h1] <= instr_ctrl_pkg::OVERFLOW_CODE;
        end
    end
endmodule

// >>> settings_store.sv
`timescale 1ns/1ns
module settings_store (
    // Clock and reset
    input  wire logic                      clock_in,
    input  wire logic                      rst_b_in,
    // Access
    input  wire logic                      write_in,
    input  wire logic [3:0]                addr_in,
    input  wire instr_ctrl_pkg::settings_t wr_data_in,
    // Read side
    output instr_ctrl_pkg::settings_t      rd_data_out,
    output logic [15:0]                    slot_valid_out
);
    instr_ctrl_pkg::settings_t mem [instr_ctrl_pkg::SLOT_COUNT];

    always_ff @(posedge clock_in) begin
        if (write_in) begin
            mem[addr_in] <= wr_data_in;
        end
        rd_data_out <= mem[addr_in];
    end

    // Slots are volatile: reset forgets all of them
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            slot_valid_out <= 16'h0000;
        end else if (write_in) begin
            slot_valid_out[addr_in] <= 1'b1;
        end
    end
endmodule

// >>> instrument_status_trigger_control.sv
`timescale 1ns/1ns
module instrument_status_trigger_control (
    // Clock and reset
    input  wire logic                      clock_in,
    input  wire logic                      rst_b_in,
    // Command port
    input  wire instr_ctrl_pkg::cmd_req_t  cmd_in,
    output logic                           cmd_ready_out,
    output logic                           resp_valid_out,
    output logic [15:0]                    resp_data_out,
    // Controller bus events
    input  wire logic                      serial_poll_in,
    input  wire logic                      group_trigger_in,
    input  wire logic                      device_clear_in,
    input  wire logic                      iface_rl_change_in,
    input  wire instr_ctrl_pkg::rl_t       iface_rl_state_in,
    output logic                           service_request_out,
    output logic                           poll_valid_out,
    output logic [7:0]                     poll_data_out,
    // Status sources and event register clear
    input  wire instr_ctrl_pkg::summary_in_t summary_in,
    input  wire logic                      error_push_in,
    input  wire logic [15:0]               error_code_in,
    input  wire logic                      pending_busy_in,
    input  wire logic                      change_done_in,
    output logic                           clear_events_out,
    output logic [7:0]                     status_byte_out,
    output logic                           waiting_for_trigger_out,
    // Output control
    output instr_ctrl_pkg::settings_t      settings_out,
    output instr_ctrl_pkg::rl_t            rl_state_out,
    output logic                           panel_keys_enable_out
);
    instr_ctrl_pkg::trig_state_t trig_state;
    instr_ctrl_pkg::trig_state_t next_trig_state;
    instr_ctrl_pkg::settings_t   slot_rd_data;
    logic [7:0]  service_request_mask;
    logic [7:0]  next_status;
    logic [15:0] slot_valid;
    logic [15:0] err_rd_data;
    logic        err_nonempty;
    logic        take;
    logic        wait_stall;
    logic        next_wait_stall;
    logic        recall_busy;
    logic        next_recall_busy;
    logic        err_query_d;
    logic        master_summary;
    logic        master_summary_d;
    logic        request_for_service;
    logic        pending_now;
    logic        trigger_hit;
    logic        do_abort;
    logic        do_clear_status;
    logic        message_available;
    logic        err_pop;
    logic        slot_write;

    assign take = cmd_in.valid && cmd_ready_out;

    function automatic logic is_cmd(input instr_ctrl_pkg::cmd_t code);
        is_cmd = take && (cmd_in.code == code);
    endfunction

    always_comb begin
        do_clear_status = is_cmd(instr_ctrl_pkg::CMD_CLEAR_STATUS);
        do_abort        = is_cmd(instr_ctrl_pkg::CMD_ABORT)
                       || is_cmd(instr_ctrl_pkg::CMD_RESET);
        trigger_hit     = (trig_state == instr_ctrl_pkg::TRIG_WAITING)
                       && (is_cmd(instr_ctrl_pkg::CMD_BUS_TRIGGER)
                       || group_trigger_in);
        err_pop         = is_cmd(instr_ctrl_pkg::CMD_QUERY_ERROR);
        slot_write      = is_cmd(instr_ctrl_pkg::CMD_SAVE);
    end
    assign pending_now     = pending_busy_in
                          || (trig_state == instr_ctrl_pkg::TRIG_TRIGGERED);

    // Submodules
    error_queue u_error_queue (
        .clock_in     (clock_in),
        .rst_b_in     (rst_b_in),
        .push_in      (error_push_in),
        .code_in      (error_code_in),
        .pop_in       (err_pop),
        .clear_in     (do_clear_status),
        .rd_data_out  (err_rd_data),
        .nonempty_out (err_nonempty)
    );

    settings_store u_settings_store (
        .clock_in       (clock_in),
        .rst_b_in       (rst_b_in),
        .write_in       (slot_write),
        .addr_in        (cmd_in.arg[3:0]),
        .wr_data_in     (settings_out),
        .rd_data_out    (slot_rd_data),
        .slot_valid_out (slot_valid)
    );

    // Status byte assembly
    assign message_available = summary_in.output_queue_nonempty
                            && !do_clear_status;
    always_comb begin
        next_status = 8'h00;
        next_status[instr_ctrl_pkg::SB_OPERATION_SUMMARY] = summary_in.operation_summary;
        next_status[instr_ctrl_pkg::SB_ESB]  = summary_in.event_status_summary;
        next_status[instr_ctrl_pkg::SB_MAV]  = message_available;
        next_status[instr_ctrl_pkg::SB_QUESTIONABLE_SUMMARY] =
            summary_in.questionable_summary;
        next_status[instr_ctrl_pkg::SB_ERR]  = err_nonempty;
        if (do_clear_status) begin
            next_status = 8'h00;
        end
        master_summary = |(next_status & service_request_mask
                           & ~(8'h01 << instr_ctrl_pkg::SB_MSS));
        next_status[instr_ctrl_pkg::SB_MSS] = master_summary;
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            status_byte_out  <= 8'h00;
            master_summary_d <= 1'b0;
            clear_events_out <= 1'b0;
        end else begin
            status_byte_out  <= next_status;
            master_summary_d <= master_summary;
            clear_events_out <= do_clear_status;
        end
    end

    // Request for service: a new reason sets it, a poll clears it
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            request_for_service <= 1'b0;
            service_request_out <= 1'b0;
        end else begin
            if (master_summary && !master_summary_d) begin
                request_for_service <= 1'b1;
                service_request_out <= 1'b1;
            end else if (serial_poll_in || do_clear_status) begin
                request_for_service <= 1'b0;
                service_request_out <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            poll_valid_out <= 1'b0;
            poll_data_out  <= 8'h00;
        end else begin
            poll_valid_out <= serial_poll_in;
            if (serial_poll_in) begin
                poll_data_out <= status_byte_out;
                poll_data_out[instr_ctrl_pkg::SB_MSS] <=
                    request_for_service;
            end
        end
    end

    // Service request mask
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            service_request_mask <= instr_ctrl_pkg::SRQ_MASK_RESET;
        end else if (is_cmd(instr_ctrl_pkg::CMD_SET_SRQ_MASK)) begin
            service_request_mask <= cmd_in.arg[7:0];
        end
    end

    // Command stalls: wait and recall
    always_comb begin
        next_wait_stall = (wait_stall || is_cmd(instr_ctrl_pkg::CMD_WAIT_PENDING))
                       && pending_now && !device_clear_in;
        next_recall_busy = is_cmd(instr_ctrl_pkg::CMD_RECALL)
                        && slot_valid[cmd_in.arg[3:0]];
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wait_stall    <= 1'b0;
            recall_busy   <= 1'b0;
            cmd_ready_out <= 1'b0;
        end else begin
            wait_stall    <= next_wait_stall;
            recall_busy   <= next_recall_busy;
            cmd_ready_out <= !next_wait_stall && !next_recall_busy;
        end
    end

    // Responses
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            err_query_d    <= 1'b0;
            resp_valid_out <= 1'b0;
            resp_data_out  <= 16'h0000;
        end else begin
            err_query_d    <= is_cmd(instr_ctrl_pkg::CMD_QUERY_ERROR);
            resp_valid_out <= 1'b0;
            if (err_query_d) begin
                resp_valid_out <= 1'b1;
                resp_data_out  <= err_rd_data;
            end else if (take) begin
                unique case (cmd_in.code)
                    instr_ctrl_pkg::CMD_QUERY_STATUS: begin
                        resp_valid_out <= 1'b1;
                        resp_data_out  <= {8'h00, status_byte_out};
                    end
                    instr_ctrl_pkg::CMD_QUERY_SRQ: begin
                        resp_valid_out <= 1'b1;
                        resp_data_out  <= {8'h00, service_request_mask};
                    end
                    instr_ctrl_pkg::CMD_QUERY_RL: begin
                        resp_valid_out <= 1'b1;
                        resp_data_out  <= {14'h0000, rl_state_out};
                    end
                    instr_ctrl_pkg::CMD_IDENTIFY: begin
                        resp_valid_out <= 1'b1;
                        unique case (cmd_in.arg[1:0])
                            2'h0: resp_data_out <= instr_ctrl_pkg::ID_MAKER;
                            2'h1: resp_data_out <= instr_ctrl_pkg::ID_MODEL;
                            2'h2: resp_data_out <= instr_ctrl_pkg::ID_SERIAL;
                            2'h3: resp_data_out <= instr_ctrl_pkg::ID_REVISION;
                        endcase
                    end
                    default: begin
                        resp_valid_out <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Remote/local state; interface change in the same cycle wins
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rl_state_out          <= instr_ctrl_pkg::RL_LOCAL;
            panel_keys_enable_out <= 1'b1;
        end else if (iface_rl_change_in) begin
            rl_state_out          <= iface_rl_state_in;
            panel_keys_enable_out <=
                (iface_rl_state_in != instr_ctrl_pkg::RL_LOCKOUT);
        end else if (is_cmd(instr_ctrl_pkg::CMD_SET_RL)
                     && (cmd_in.arg[1:0] != 2'h3)) begin
            rl_state_out          <= instr_ctrl_pkg::rl_t'(cmd_in.arg[1:0]);
            panel_keys_enable_out <=
                (cmd_in.arg[1:0] != instr_ctrl_pkg::RL_LOCKOUT);
        end
    end

    // Output settings
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            settings_out <= instr_ctrl_pkg::SETTINGS_RESET;
        end else if (is_cmd(instr_ctrl_pkg::CMD_RESET)) begin
            settings_out <= instr_ctrl_pkg::SETTINGS_RESET;
        end else if (recall_busy) begin
            settings_out <= slot_rd_data;
        end else if (trigger_hit) begin
            settings_out.volt <= settings_out.volt_trig;
            settings_out.curr <= settings_out.curr_trig;
        end else if (take) begin
            unique case (cmd_in.code)
                instr_ctrl_pkg::CMD_SET_VOLT:
                    settings_out.volt <= cmd_in.arg;
                instr_ctrl_pkg::CMD_SET_CURR:
                    settings_out.curr <= cmd_in.arg;
                instr_ctrl_pkg::CMD_SET_VOLT_LIM:
                    settings_out.volt_lim <= cmd_in.arg;
                instr_ctrl_pkg::CMD_SET_VOLT_TRIG:
                    settings_out.volt_trig <= cmd_in.arg;
                instr_ctrl_pkg::CMD_SET_CURR_TRIG:
                    settings_out.curr_trig <= cmd_in.arg;
                instr_ctrl_pkg::CMD_SET_VOLT_PROT:
                    settings_out.volt_prot <= cmd_in.arg;
                instr_ctrl_pkg::CMD_SET_OUTPUT:
                    settings_out.output_on <= cmd_in.arg[0];
                instr_ctrl_pkg::CMD_SET_CURR_PROT:
                    settings_out.curr_prot <= cmd_in.arg[0];
                instr_ctrl_pkg::CMD_SET_CAL:
                    settings_out.cal_on <= cmd_in.arg[0];
                instr_ctrl_pkg::CMD_SET_CONT:
                    settings_out.continuous_arm <= cmd_in.arg[0];
                default: begin
                end
            endcase
        end
    end

    // Trigger sequencer
    always_comb begin
        next_trig_state = trig_state;
        unique case (trig_state)
            instr_ctrl_pkg::TRIG_IDLE: begin
                if (is_cmd(instr_ctrl_pkg::CMD_INITIATE)
                    || settings_out.continuous_arm) begin
                    next_trig_state = instr_ctrl_pkg::TRIG_WAITING;
                end
            end
            instr_ctrl_pkg::TRIG_WAITING: begin
                if (trigger_hit) begin
                    next_trig_state = instr_ctrl_pkg::TRIG_TRIGGERED;
                end
            end
            instr_ctrl_pkg::TRIG_TRIGGERED: begin
                if (change_done_in) begin
                    next_trig_state = instr_ctrl_pkg::TRIG_IDLE;
                end
            end
            default: next_trig_state = instr_ctrl_pkg::TRIG_IDLE;
        endcase
        if (do_abort) begin
            next_trig_state = instr_ctrl_pkg::TRIG_IDLE;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            trig_state              <= instr_ctrl_pkg::TRIG_IDLE;
            waiting_for_trigger_out <= 1'b0;
        end else begin
            trig_state              <= next_trig_state;
            waiting_for_trigger_out <=
                (next_trig_state != instr_ctrl_pkg::TRIG_IDLE);
        end
    end
endmodule

// >>> istc_chk.sv
`timescale 1ns/1ns
module istc_chk (
    // Clock and reset
    input wire logic                      clock_in,
    input wire logic                      rst_b_in,
    // Watched ports
    input wire instr_ctrl_pkg::cmd_req_t  cmd_in,
    input wire logic                      cmd_ready_out,
    input wire logic                      serial_poll_in,
    input wire logic                      group_trigger_in,
    input wire logic                      service_request_out,
    input wire logic                      poll_valid_out,
    input wire logic [7:0]                status_byte_out,
    input wire logic                      waiting_for_trigger_out,
    input wire instr_ctrl_pkg::settings_t settings_out,
    input wire instr_ctrl_pkg::rl_t       rl_state_out,
    input wire logic                      panel_keys_enable_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);
    wire taken = cmd_in.valid && cmd_ready_out;
    a_low_bits_zero: assert property (status_byte_out[1:0] == 2'h0)
        else $error("low status bits set");
    a_poll_answer: assert property (serial_poll_in |=> poll_valid_out)
        else $error("poll not answered");
    a_srq_needs_mss: assert property (
        $rose(service_request_out) |-> status_byte_out[6])
        else $error("request without summary");
    a_poll_clears: assert property (
        serial_poll_in |=> !service_request_out || $rose(status_byte_out[6]))
        else $error("poll left request set");
    a_keys_lockout: assert property (
        panel_keys_enable_out == (rl_state_out != instr_ctrl_pkg::RL_LOCKOUT))
        else $error("panel keys wrong");
    a_arm_waits: assert property (taken && !waiting_for_trigger_out &&
        cmd_in.code == instr_ctrl_pkg::CMD_INITIATE |=> waiting_for_trigger_out)
        else $error("initiate did not arm");
    a_trig_apply: assert property (waiting_for_trigger_out &&
        group_trigger_in |=> settings_out.volt == $past(settings_out.volt_trig))
        else $error("trigger level not applied");
    a_rl_survives: assert property (taken &&
        cmd_in.code == instr_ctrl_pkg::CMD_RESET |=> $stable(rl_state_out))
        else $error("reset moved remote state");
endmodule
bind instrument_status_trigger_control istc_chk chk (.clock_in, .rst_b_in,
    .cmd_in, .cmd_ready_out, .serial_poll_in, .group_trigger_in,
    .service_request_out, .poll_valid_out, .status_byte_out,
    .waiting_for_trigger_out, .settings_out, .rl_state_out,
    .panel_keys_enable_out);

// >>> bus_ctrl_model.sv
`timescale 1ns/1ns
module bus_ctrl_model (
    // Clock and poll answer
    input  wire logic       clock_in,
    input  wire logic       poll_valid_in,
    input  wire logic [7:0] poll_data_in,
    // Bus events, idle low
    output logic            serial_poll_out,
    output logic            group_trigger_out
);
    logic [7:0] polled;
    initial serial_poll_out = 1'b0;
    initial group_trigger_out = 1'b0;
    always_ff @(posedge clock_in) begin
        if (poll_valid_in) begin
            polled <= poll_data_in;
        end
    end
    task automatic poll();
        @(negedge clock_in);
        serial_poll_out = 1'b1;
        @(negedge clock_in);
        serial_poll_out = 1'b0;
    endtask
    // Group trigger from the bus; the CMD_BUS_TRIGGER command also triggers
    task automatic trig();
        @(negedge clock_in);
        group_trigger_out = 1'b1;
        @(negedge clock_in);
        group_trigger_out = 1'b0;
    endtask
endmodule

// >>> testbench.sv
`timescale 1ns/1ns
module testbench;
    logic clock_in, rst_b_in, error_push_in, change_done_in, sp, gt;
    logic cmd_ready_out, resp_valid_out, service_request_out, poll_valid_out;
    logic waiting_for_trigger_out, panel_keys_enable_out;
    logic [15:0] error_code_in, resp_data_out;
    logic [7:0] poll_data_out, status_byte_out;
    instr_ctrl_pkg::cmd_req_t cmd_in;
    instr_ctrl_pkg::summary_in_t summary_in;
    instr_ctrl_pkg::settings_t settings_out;
    instr_ctrl_pkg::rl_t rl_state_out;
    int err_total = 0;
    int checks_done = 0;
    instrument_status_trigger_control uut (.clock_in, .rst_b_in, .cmd_in,
        .cmd_ready_out, .resp_valid_out, .resp_data_out, .serial_poll_in(sp),
        .group_trigger_in(gt), .device_clear_in(1'b0),
        .iface_rl_change_in(1'b0), .iface_rl_state_in(instr_ctrl_pkg::RL_LOCAL),
        .service_request_out, .poll_valid_out, .poll_data_out, .summary_in,
        .error_push_in, .error_code_in, .pending_busy_in(1'b0),
        .change_done_in, .clear_events_out(), .status_byte_out,
        .waiting_for_trigger_out, .settings_out, .rl_state_out,
        .panel_keys_enable_out);
    bus_ctrl_model ctrl (.clock_in, .poll_valid_in(poll_valid_out),
        .poll_data_in(poll_data_out), .serial_poll_out(sp),
        .group_trigger_out(gt));
    task automatic chk(logic [15:0] seen, logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cmd(instr_ctrl_pkg::cmd_t c, logic [15:0] a);
        @(negedge clock_in);
        cmd_in = '{1'b1, c, a};
        while (cmd_ready_out !== 1'b1) @(negedge clock_in);
        @(negedge clock_in);
        cmd_in.valid = 1'b0;
        repeat (2) @(negedge clock_in);
    endtask
    task automatic t_srq();
        cmd(instr_ctrl_pkg::CMD_SET_SRQ_MASK, 16'h0080);
        summary_in.operation_summary = 1'b1;
        repeat (3) @(negedge clock_in);
        chk(service_request_out, 1'b1);
        cmd(instr_ctrl_pkg::CMD_QUERY_STATUS, 16'h0000);
        chk(resp_data_out, 16'h00c0);
        cmd(instr_ctrl_pkg::CMD_QUERY_SRQ, 16'h0000);
        chk(resp_data_out, 16'h0080);
        ctrl.poll();
        @(negedge clock_in);
        chk(ctrl.polled, 8'hc0);
        chk(status_byte_out, 8'hc0);
        chk(service_request_out, 1'b0);
        ctrl.poll();
        @(negedge clock_in);
        chk(ctrl.polled, 8'h80);
        summary_in.operation_summary = 1'b0;
    endtask
    task automatic t_err();
        for (int i = 1; i <= 9; i++) begin
            error_code_in = 16'(i);
            error_push_in = 1'b1;
            @(negedge clock_in);
        end
        error_push_in = 1'b0;
        @(negedge clock_in);
        chk(status_byte_out[2], 1'b1);
        for (int i = 1; i <= 9; i++) begin
            cmd(instr_ctrl_pkg::CMD_QUERY_ERROR, 16'h0000);
            chk(resp_data_out, i < 8 ? 16'(i) : i == 8 ? 16'hfea2 : 16'h0);
        end
        chk(status_byte_out[2], 1'b0);
    endtask
    task automatic t_trig();
        cmd(instr_ctrl_pkg::CMD_SET_VOLT_TRIG, 16'h0555);
        ctrl.trig();
        chk(settings_out.volt, 16'h0000);
        cmd(instr_ctrl_pkg::CMD_INITIATE, 16'h0000);
        chk(waiting_for_trigger_out, 1'b1);
        ctrl.trig();
        chk(settings_out.volt, 16'h0555);
        cmd(instr_ctrl_pkg::CMD_WAIT_PENDING, 16'h0000);
        chk(cmd_ready_out, 1'b0);
        change_done_in = 1'b1;
        @(negedge clock_in);
        change_done_in = 1'b0;
        @(negedge clock_in);
        chk(waiting_for_trigger_out, 1'b0);
        cmd(instr_ctrl_pkg::CMD_SET_CONT, 16'h0001);
        chk(waiting_for_trigger_out, 1'b1);
    endtask
    task automatic t_slot();
        cmd(instr_ctrl_pkg::CMD_SET_VOLT_PROT, 16'h0123);
        cmd(instr_ctrl_pkg::CMD_SAVE, 16'h0003);
        cmd(instr_ctrl_pkg::CMD_SET_VOLT_PROT, 16'h0456);
        cmd(instr_ctrl_pkg::CMD_RECALL, 16'h0003);
        chk(settings_out.volt_prot, 16'h0123);
        cmd(instr_ctrl_pkg::CMD_RECALL, 16'h0009);
        chk(settings_out.volt_prot, 16'h0123);
    endtask
    task automatic t_rl();
        cmd(instr_ctrl_pkg::CMD_SET_RL, 16'h0002);
        chk(panel_keys_enable_out, 1'b0);
        cmd(instr_ctrl_pkg::CMD_RESET, 16'h0000);
        chk(rl_state_out, instr_ctrl_pkg::RL_LOCKOUT);
        chk(settings_out.volt_prot, 16'hffff);
        chk(waiting_for_trigger_out, 1'b0);
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end
    initial begin
        #40000;
        err_total++;
        report_and_stop();
    end
    initial begin
        {rst_b_in, error_push_in, change_done_in} = 3'h0;
        {cmd_in, summary_in, error_code_in} = '0;
        repeat (6) @(negedge clock_in);
        rst_b_in = 1'b1;
        @(negedge clock_in);
        t_srq();
        t_err();
        t_trig();
        t_slot();
        t_rl();
        report_and_stop();
    end
endmodule
